/* File: vci_inserter.sv */
// Purpose: Inserts caption and copy-generation waveforms into blanked lines
// Assumes: Line number and field flag come from the encoder timing generator
// Notes:   Caption data is single-buffered and sampled at the caption line start
//
// Functional notes
// - Send captions on line 21 odd field and line 284 even field.
// - Caption line opens with seven sine run-in cycles locked to bit timing.
// - After run-in hold blanking two bit periods, then a start bit at one.
// - Send two bytes of seven data bits plus odd parity each.
// - Line 21 uses basic caption registers; line 284 uses extended ones.
// - With captions on, generate those lines fully and ignore pixel input.
// - Caption bytes are single-buffered and go out on the next caption line.
// - Send copy-generation data on line 20 odd and line 283 even.
// - Separate enables for copy-generation output in odd and even fields.
// - Copy-generation data goes out only in NTSC mode.
// - Twenty payload bits follow a reference pulse one bit long at full level.
// - C0-C7 from third byte, C8-C15 second byte, C16-C19 first byte low nibble.
// - With auto CRC on, C14-C19 are computed from C0-C13.
// - CRC polynomial x^6+x+1, register preset to all ones.
// - With auto CRC off all twenty bits go out as stored.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps

module vci_inserter
  import vci_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       line_start_i,
  input  wire logic [9:0] line_num_i,
  input  wire logic       field_odd_i,
  input  wire logic [9:0] pixel_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic      [9:0] video_o,
  output logic            insert_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] cc_basic_lo_q;
  logic [7:0] cc_basic_hi_q;
  logic [7:0] cc_ext_lo_q;
  logic [7:0] cc_ext_hi_q;
  logic [7:0] cgms_byte_first_q;
  logic [7:0] cgms_byte_second_q;
  logic [7:0] cgms_byte_third_q;
  logic [7:0] ctrl_q;

  vci_state_t       state_q;
  logic             kind_cc_q;
  logic             crc_auto_q;
  logic             ovr_q;
  logic [SYM_W-1:0] sym_q;
  logic [4:0]       bit_q;
  logic [11:0]      cnt_q;
  logic [3:0]       phase_q;

  // Odd parity bit on top of seven character bits
  function automatic logic [7:0] vci_cc_byte(input logic [7:0] b);
    return {~^b[6:0], b[6:0]};
  endfunction

  // Serial CRC over C0..C13, fed low bit first
  function automatic logic [5:0] vci_crc(input logic [13:0] d);
    logic [5:0] c;
    logic       fb;
    c = CRC_PRESET;
    for (int i = 0; i < 14; i++)
    begin
      fb = d[i] ^ c[5];
      c  = {c[4:0], 1'b0} ^ ({6{fb}} & CRC_POLY);
    end
    return c;
  endfunction

  // Host writes; unmapped addresses are ignored
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cc_basic_lo_q      <= REG_RESET;
      cc_basic_hi_q      <= REG_RESET;
      cc_ext_lo_q        <= REG_RESET;
      cc_ext_hi_q        <= REG_RESET;
      cgms_byte_first_q  <= REG_RESET;
      cgms_byte_second_q <= REG_RESET;
      cgms_byte_third_q  <= REG_RESET;
      ctrl_q             <= REG_RESET;
    end
    else if (wr_i)
    begin
      if (addr_i == ADDR_CC_BASIC_LO)
        cc_basic_lo_q <= wdata_i;
      else if (addr_i == ADDR_CC_BASIC_HI)
        cc_basic_hi_q <= wdata_i;
      else if (addr_i == ADDR_CC_EXT_LO)
        cc_ext_lo_q <= wdata_i;
      else if (addr_i == ADDR_CC_EXT_HI)
        cc_ext_hi_q <= wdata_i;
      else if (addr_i == ADDR_CGMS_FIRST)
        cgms_byte_first_q <= wdata_i;
      else if (addr_i == ADDR_CGMS_SECOND)
        cgms_byte_second_q <= wdata_i;
      else if (addr_i == ADDR_CGMS_THIRD)
        cgms_byte_third_q <= wdata_i;
      else if (addr_i == ADDR_CTRL)
        ctrl_q <= wdata_i;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else if (!rd_i)
      rdata_o <= 8'h00;
    else if (addr_i == ADDR_CC_BASIC_LO)
      rdata_o <= cc_basic_lo_q;
    else if (addr_i == ADDR_CC_BASIC_HI)
      rdata_o <= cc_basic_hi_q;
    else if (addr_i == ADDR_CC_EXT_LO)
      rdata_o <= cc_ext_lo_q;
    else if (addr_i == ADDR_CC_EXT_HI)
      rdata_o <= cc_ext_hi_q;
    else if (addr_i == ADDR_CGMS_FIRST)
      rdata_o <= cgms_byte_first_q;
    else if (addr_i == ADDR_CGMS_SECOND)
      rdata_o <= cgms_byte_second_q;
    else if (addr_i == ADDR_CGMS_THIRD)
      rdata_o <= cgms_byte_third_q;
    else if (addr_i == ADDR_CTRL)
      rdata_o <= ctrl_q;
    else if (addr_i == ADDR_STATUS)
      rdata_o <= {5'h00, ovr_q, kind_cc_q, state_q != VCI_IDLE};
    else
      rdata_o <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line selection and symbol loading
  logic        cc_hit;
  logic        cgms_hit;
  logic [7:0]  cc_lo_sel;
  logic [7:0]  cc_hi_sel;
  logic [19:0] cgms_raw;
  logic [19:0] cgms_pay;

  // Line and field come straight from the timing generator
  assign cc_hit = line_start_i &&
                  ((field_odd_i && line_num_i == LINE_CC_ODD && ctrl_q[CTRL_CC_ODD_BIT]) ||
                   (!field_odd_i && line_num_i == LINE_CC_EVEN &&
                    ctrl_q[CTRL_CC_EVEN_BIT]));
  assign cgms_hit = line_start_i && ctrl_q[CTRL_NTSC_BIT] &&
                    ((field_odd_i && line_num_i == LINE_CGMS_ODD &&
                      cgms_byte_first_q[CGMS_EN_ODD_BIT]) ||
                     (!field_odd_i && line_num_i == LINE_CGMS_EVEN &&
                      cgms_byte_first_q[CGMS_EN_EVEN_BIT]));

  // Basic pair in odd fields, extended pair in even fields
  assign cc_lo_sel = field_odd_i ? cc_basic_lo_q : cc_ext_lo_q;
  assign cc_hi_sel = field_odd_i ? cc_basic_hi_q : cc_ext_hi_q;

  // Payload assembly, CRC replaces the top six bits when enabled
  assign cgms_raw = {cgms_byte_first_q[3:0], cgms_byte_second_q, cgms_byte_third_q};
  assign cgms_pay = cgms_byte_first_q[CGMS_CRC_AUTO_BIT] ?
                    {vci_crc(cgms_raw[13:0]), cgms_raw[13:0]} :
                    cgms_raw;

  // Sequencer: wait for the start offset, then shift symbols out
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q    <= VCI_IDLE;
      kind_cc_q  <= 1'b0;
      crc_auto_q <= 1'b0;
      sym_q      <= '0;
      bit_q      <= 5'd0;
      cnt_q      <= 12'd0;
      phase_q    <= 4'd0;
    end
    else
    begin
      case (state_q)
        VCI_IDLE:
        begin
          if (cc_hit)
          begin
            state_q   <= VCI_WAIT; // Bytes taken at line start, no extra latency
            kind_cc_q <= 1'b1;
            sym_q     <= {vci_cc_byte(cc_hi_sel), vci_cc_byte(cc_lo_sel),
                          1'b1, {CC_START_IDX{1'b0}}};
            cnt_q     <= 12'(CC_START_CYC - 1);
          end
          else if (cgms_hit)
          begin
            state_q    <= VCI_WAIT;
            kind_cc_q  <= 1'b0;
            crc_auto_q <= cgms_byte_first_q[CGMS_CRC_AUTO_BIT];
            sym_q      <= SYM_W'({cgms_pay, 1'b1});
            cnt_q      <= 12'(CGMS_START_CYC - 1);
          end
        end
        VCI_WAIT:
        begin
          if (cnt_q == 12'd0)
          begin
            state_q <= VCI_SEND;
            bit_q   <= 5'd0;
            phase_q <= 4'd0;
            cnt_q   <= kind_cc_q ? 12'(CC_BIT_CYC - 1) : 12'(CGMS_BIT_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 12'd1;
        end
        VCI_SEND:
        begin
          if (kind_cc_q && (cnt_q % 12'(CC_PHASE_CYC)) == 12'd0) // Run-in steps
            phase_q <= phase_q + 4'd1;
          if (cnt_q == 12'd0)
          begin
            sym_q <= sym_q >> 1;
            bit_q <= bit_q + 5'd1;
            cnt_q <= kind_cc_q ? 12'(CC_BIT_CYC - 1) : 12'(CGMS_BIT_CYC - 1);
            if (bit_q == (kind_cc_q ? 5'(CC_SYMBOLS - 1) : 5'(CGMS_SYMBOLS - 1)))
              state_q <= VCI_IDLE;
          end
          else
            cnt_q <= cnt_q - 12'd1;
        end
        default:
          state_q <= VCI_IDLE;
      endcase
    end
  end

  // Whole caption line is owned by the inserter until the next line starts
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ovr_q <= 1'b0;
    else if (line_start_i)
      ovr_q <= cc_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output sample
  logic [9:0] sine_val;

  // Sixteen-step sine around mid level; a small table keeps the run-in exact
  localparam logic [9:0] SINE_TBL [16] = '{10'h080, 10'h0b1, 10'h0db, 10'h0f6, 10'h100,
    10'h0f6, 10'h0db, 10'h0b1, 10'h080, 10'h04f, 10'h025, 10'h00a, 10'h000, 10'h00a,
    10'h025, 10'h04f};
  assign sine_val = SINE_TBL[phase_q];

  // Pixel input is ignored for the whole of an enabled caption line
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      video_o  <= LVL_BLANK;
      insert_o <= 1'b0;
    end
    else if (state_q == VCI_SEND)
    begin
      insert_o <= 1'b1;
      if (kind_cc_q && bit_q < 5'(CC_RUNIN_BITS))
        video_o <= LVL_BLANK + sine_val;
      else
        video_o <= sym_q[0] ? LVL_HIGH : LVL_BLANK;
    end
    else
    begin
      insert_o <= ovr_q;
      video_o  <= ovr_q ? LVL_BLANK : pixel_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_cc_lines;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_WAIT && $past(state_q) == VCI_IDLE && kind_cc_q) |->
      ($past(field_odd_i) && $past(line_num_i) == LINE_CC_ODD) ||
      (!$past(field_odd_i) && $past(line_num_i) == LINE_CC_EVEN);
  endproperty
  a_cc_lines: assert property (p_cc_lines)
    else $error("caption started on a wrong line");
  property p_runin_sine;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_SEND && kind_cc_q && bit_q < 5'd7 && phase_q == 4'h4) |=>
      video_o == LVL_BLANK + 10'h100;
  endproperty
  a_runin_sine: assert property (p_runin_sine)
    else $error("run-in peak level wrong");
  property p_gap_start;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_SEND && kind_cc_q && bit_q == 5'd9) |=>
      video_o == LVL_HIGH && $past(bit_q, 1) == 5'd9;
  endproperty
  a_gap_start: assert property (p_gap_start)
    else $error("start bit not at high level");
  property p_gap_blank;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_SEND && kind_cc_q && (bit_q == 5'd7 || bit_q == 5'd8)) |=>
      video_o == LVL_BLANK;
  endproperty
  a_gap_blank: assert property (p_gap_blank)
    else $error("gap after run-in not at blanking");
  property p_parity;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_WAIT && kind_cc_q) |-> (^sym_q[17:10]) && (^sym_q[25:18]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("caption byte parity not odd");
  property p_cc_source;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_WAIT && $past(state_q) == VCI_IDLE && kind_cc_q) |->
      sym_q[16:10] == ($past(field_odd_i) ? $past(cc_basic_lo_q[6:0]) :
                                            $past(cc_ext_lo_q[6:0]));
  endproperty
  a_cc_source: assert property (p_cc_source)
    else $error("caption byte from wrong register");
  property p_pixel_ignored;
    @(posedge clock_i) disable iff (!rstn_i)
    (ovr_q && state_q != VCI_SEND) |=> video_o == LVL_BLANK && insert_o;
  endproperty
  a_pixel_ignored: assert property (p_pixel_ignored)
    else $error("pixel input leaked onto caption line");
  property p_cgms_gate;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_WAIT && $past(state_q) == VCI_IDLE && !kind_cc_q) |->
      $past(ctrl_q[CTRL_NTSC_BIT]) &&
      ($past(field_odd_i) ? $past(cgms_byte_first_q[CGMS_EN_ODD_BIT]) &&
                            $past(line_num_i) == LINE_CGMS_ODD :
                            $past(cgms_byte_first_q[CGMS_EN_EVEN_BIT]) &&
                            $past(line_num_i) == LINE_CGMS_EVEN);
  endproperty
  a_cgms_gate: assert property (p_cgms_gate)
    else $error("copy-generation line sent while not permitted");
  property p_cgms_crc;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_WAIT && !kind_cc_q && crc_auto_q) |->
      sym_q[20:15] == vci_crc(sym_q[14:1]) && sym_q[0];
  endproperty
  a_cgms_crc: assert property (p_cgms_crc)
    else $error("automatic CRC mismatch");
  property p_cgms_raw;
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == VCI_WAIT && $past(state_q) == VCI_IDLE && !kind_cc_q && !crc_auto_q) |->
      sym_q[20:1] == {$past(cgms_byte_first_q[3:0]), $past(cgms_byte_second_q),
                      $past(cgms_byte_third_q)} && sym_q[0];
  endproperty
  a_cgms_raw: assert property (p_cgms_raw)
    else $error("stored payload not sent as written");
endmodule

/* File: vci_pkg.sv */
// Purpose: Shared constants for the caption and copy-generation line inserter
// Assumes: 40 MHz pixel-domain clock, 8-bit register port, 10-bit video samples
// Notes:   Timing figures are in ns; cycle counts are derived from them
package vci_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 25;

  // Register indices on the plain port
  localparam logic [3:0] ADDR_CC_BASIC_LO = 4'h0;
  localparam logic [3:0] ADDR_CC_BASIC_HI = 4'h1;
  localparam logic [3:0] ADDR_CC_EXT_LO   = 4'h2;
  localparam logic [3:0] ADDR_CC_EXT_HI   = 4'h3;
  localparam logic [3:0] ADDR_CGMS_FIRST  = 4'h4;
  localparam logic [3:0] ADDR_CGMS_SECOND = 4'h5;
  localparam logic [3:0] ADDR_CGMS_THIRD  = 4'h6;
  localparam logic [3:0] ADDR_CTRL        = 4'h7;
  localparam logic [3:0] ADDR_STATUS      = 4'h8;

  // Field positions in cgms_byte_first
  localparam int CGMS_CRC_AUTO_BIT = 4;
  localparam int CGMS_EN_ODD_BIT   = 5;
  localparam int CGMS_EN_EVEN_BIT  = 6;

  // Field positions in the control register
  localparam int CTRL_CC_ODD_BIT  = 0;
  localparam int CTRL_CC_EVEN_BIT = 1;
  localparam int CTRL_NTSC_BIT    = 2;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Target lines
  localparam logic [9:0] LINE_CC_ODD    = 10'd21;
  localparam logic [9:0] LINE_CC_EVEN   = 10'd284;
  localparam logic [9:0] LINE_CGMS_ODD  = 10'd20;
  localparam logic [9:0] LINE_CGMS_EVEN = 10'd283;

  // Symbol layout of a caption line: run-in, gap, start bit, two bytes
  localparam int CC_RUNIN_BITS = 7;
  localparam int CC_GAP_BITS   = 2;
  localparam int CC_START_IDX  = CC_RUNIN_BITS + CC_GAP_BITS;
  localparam int CC_DATA_IDX   = CC_START_IDX + 1;
  localparam int CC_SYMBOLS    = CC_DATA_IDX + 16;
  localparam int CGMS_SYMBOLS  = 21;
  localparam int SYM_W         = CC_SYMBOLS;

  // Timing: one run-in phase step, bit periods, start offsets
  localparam int CC_PHASE_NS    = 125;
  localparam int CC_PHASE_CYC   = CC_PHASE_NS / CLK_PERIOD_NS;
  localparam int CC_BIT_CYC     = 16 * CC_PHASE_CYC;
  localparam int CGMS_BIT_NS    = 2234;
  localparam int CGMS_BIT_CYC   = CGMS_BIT_NS / CLK_PERIOD_NS;
  localparam int CC_START_NS    = 10500;
  localparam int CC_START_CYC   = (CC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CGMS_START_NS  = 11200;
  localparam int CGMS_START_CYC = (CGMS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Output levels
  localparam logic [9:0] LVL_BLANK = 10'h100;
  localparam logic [9:0] LVL_HIGH  = 10'h200;
  localparam logic [9:0] SINE_MID  = 10'h080;

  // CRC generator x^6 + x + 1, preset all ones
  localparam logic [5:0] CRC_POLY   = 6'h03;
  localparam logic [5:0] CRC_PRESET = 6'h3f;

  // Sequencer states, Gray along idle -> wait -> send
  typedef enum logic [1:0] {
    VCI_IDLE = 2'b00,
    VCI_WAIT = 2'b01,
    VCI_SEND = 2'b11
  } vci_state_t;

endpackage

/* File: vci_host_model.sv */
// Purpose: Host side of the register port, loading caption and copy bytes
// Assumes: One access per clock, strobes driven just after the rising edge
// Notes:   Accesses are queued by the bench and issued back to back
`timescale 1ns/1ps

module vci_host_model
  import vci_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  output logic      [3:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // Pending accesses {read, addr, data}
  logic [12:0] cmd_q[$];
  logic [12:0] cmd;

  // Queue one write
  task automatic push_wr(input logic [3:0] a, input logic [7:0] d);
    cmd_q.push_back({1'b0, a, d});
  endtask

  // Both bytes of a field go in together, so a code pair never splits
  task automatic load_cc(input logic ext, input logic [7:0] b1, input logic [7:0] b2);
    push_wr(ext ? ADDR_CC_EXT_LO : ADDR_CC_BASIC_LO, b1);
    push_wr(ext ? ADDR_CC_EXT_HI : ADDR_CC_BASIC_HI, b2);
  endtask

  ////////////////////////////////////////
  // One strobe per cycle; queue drained before the target line starts
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_o    <= 1'b0;
      rd_o    <= 1'b0;
      addr_o  <= 4'h0;
      wdata_o <= 8'h00;
    end
    else if (cmd_q.size() > 0)
    begin
      cmd = cmd_q.pop_front();
      rd_o    <= cmd[12];
      wr_o    <= !cmd[12];
      addr_o  <= cmd[11:8];
      wdata_o <= cmd[7:0];
    end
    else
    begin
      wr_o <= 1'b0;
      rd_o <= 1'b0;
    end
  end
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the blanking-line inserter
// Assumes: Bench plays the timing generator; host model drives the registers
// Notes:   Line end is taken as 2700 cycles, past the longest waveform
`timescale 1ns/1ps

`define VCI_CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end

module tb
  import vci_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        line_start_i = 1'b0;
  logic [9:0]  line_num_i = 10'h000;
  logic        field_odd_i = 1'b0;
  logic [9:0]  pixel_i = 10'h000;
  logic [3:0]  addr_w;
  logic [7:0]  wdata_w;
  logic        wr_w;
  logic        rd_w;
  logic [7:0]  rdata_o;
  logic [9:0]  video_o;
  logic        insert_o;
  logic        rd_seen = 1'b0;
  logic        vprobe = 1'b0;
  logic [7:0]  q_rd[$];
  logic [10:0] q_vid[$];
  logic [7:0]  exp_r;
  logic [10:0] exp_v;
  logic [9:0]  pix;
  integer      seed;
  int          n_mismatch = 0;
  int          checked = 0;
  int          t;

  // 40 MHz clock
  always #12.5 clock_i = ~clock_i;

  vci_host_model host_u (.clock_i(clock_i), .rstn_i(rstn_i), .addr_o(addr_w),
    .wdata_o(wdata_w), .wr_o(wr_w), .rd_o(rd_w));

  vci_inserter dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .line_start_i(line_start_i),
    .line_num_i(line_num_i), .field_odd_i(field_odd_i), .pixel_i(pixel_i),
    .addr_i(addr_w), .wdata_i(wdata_w), .wr_i(wr_w), .rd_i(rd_w),
    .rdata_o(rdata_o), .video_o(video_o), .insert_o(insert_o));

  ////////////////////////////////////////
  // Monitor: read data stands only in the cycle after the strobe
  always @(posedge clock_i) rd_seen <= rd_w;
  always @(negedge clock_i)
  begin
    if (rd_seen)
    begin
      exp_r = q_rd.pop_front();
      `VCI_CHECK("rdata_o", exp_r, rdata_o)
    end
    if (vprobe)
    begin
      exp_v = q_vid.pop_front();
      `VCI_CHECK("insert_o,video_o", exp_v, {insert_o, video_o})
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well above the ~30k cycles the sequence needs
  initial
  begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    host_u.cmd_q.push_back({1'b1, a, 8'h00});
  endtask

  // Bounded wait for the host queue to empty
  task automatic drain();
    for (int i = 0; i < 64 && host_u.cmd_q.size() > 0; i++) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
  endtask

  // Note an expected output pair for cycle 'at' of the line
  task automatic probe(input int at, input logic [10:0] e);
    while (t < at)
    begin
      @(posedge clock_i);
      t++;
    end
    q_vid.push_back(e);
    vprobe <= 1'b1;
    @(posedge clock_i);
    t++;
    vprobe <= 1'b0;
  endtask

  // One video line; kind 0 caption, 1 copy-generation, 2 passthrough
  task automatic run_line(input logic [9:0] num, input logic odd, input int kind,
                          input logic [25:0] bits);
    int st;
    int bc;
    int n;
    int f;
    pix = $random(seed);
    pixel_i      <= pix;
    line_num_i   <= num;
    field_odd_i  <= odd;
    line_start_i <= 1'b1;
    @(posedge clock_i);
    line_start_i <= 1'b0;
    t  = 0;
    st = (kind == 0) ? CC_START_CYC + 2 : CGMS_START_CYC + 2;
    bc = (kind == 0) ? CC_BIT_CYC : CGMS_BIT_CYC;
    n  = (kind == 0) ? 26 : (kind == 1) ? 21 : 0;
    f  = (kind == 0) ? 7 : 0;
    if (kind == 0)
    begin
      rd_exp(ADDR_STATUS, 8'h07);
      probe(100, {1'b1, LVL_BLANK});
    end
    else
      probe(100, {1'b0, pix});
    if (kind == 2)
      probe(1500, {1'b0, pix});
    // Mid-symbol samples; gap, start and data for captions
    for (int k = f; k < n; k++)
      probe(st + k * bc + bc / 2, {1'b1, bits[k] ? LVL_HIGH : LVL_BLANK});
    // Caption override holds until the next line start
    probe(2700, (kind == 0) ? {1'b1, LVL_BLANK} : {1'b0, pix});
  endtask

  function automatic logic [25:0] cc_bits(input logic [7:0] b1, input logic [7:0] b2);
    return {~^b2[6:0], b2[6:0], ~^b1[6:0], b1[6:0], 1'b1, 2'b00, 7'h00};
  endfunction

  // Reference pulse, then C0..C19 with optional CRC over C0..C13
  function automatic logic [25:0] cg_bits(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c);
    logic [19:0] p;
    logic [5:0]  crc;
    logic        fb;
    p   = {a[3:0], b, c};
    crc = CRC_PRESET;
    for (int i = 0; i < 14; i++)
    begin
      fb  = p[i] ^ crc[5];
      crc = {crc[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
    end
    if (a[CGMS_CRC_AUTO_BIT])
      p[19:14] = crc;
    return {5'h00, p, 1'b1};
  endfunction

  task automatic cg_case(input logic [7:0] ctl, input logic [7:0] a, input logic [9:0] num,
                         input logic odd, input int kind);
    logic [7:0] b;
    logic [7:0] c;
    b = $random(seed);
    c = $random(seed);
    host_u.push_wr(ADDR_CTRL, ctl);
    host_u.push_wr(ADDR_CGMS_FIRST, a);
    host_u.push_wr(ADDR_CGMS_SECOND, b);
    host_u.push_wr(ADDR_CGMS_THIRD, c);
    drain();
    run_line(num, odd, kind, cg_bits(a, b, c));
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] b1;
    logic [7:0] b2;
    seed = 32'heddb;
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    // Reset values everywhere, unmapped places included
    for (int a = 0; a < 16; a++) rd_exp(a[3:0], REG_RESET);
    host_u.push_wr(4'hf, 8'h5a);
    rd_exp(4'hf, 8'h00);
    host_u.push_wr(ADDR_CTRL, 8'h05);
    rd_exp(ADDR_CTRL, 8'h05);
    drain();
    // Basic caption on line 21 odd, written just before the line
    b1 = $random(seed);
    b2 = $random(seed);
    host_u.load_cc(1'b0, b1, b2);
    drain();
    run_line(LINE_CC_ODD, 1'b1, 0, cc_bits(b1, b2));
    // Even caption disabled, then enabled from the extended pair
    b1 = $random(seed);
    b2 = $random(seed);
    host_u.load_cc(1'b1, b1, b2);
    drain();
    run_line(LINE_CC_EVEN, 1'b0, 2, 26'h0);
    host_u.push_wr(ADDR_CTRL, 8'h07);
    drain();
    run_line(LINE_CC_EVEN, 1'b0, 0, cc_bits(b1, b2));
    // Nulled field, and line 21 in the wrong field
    host_u.load_cc(1'b0, 8'h00, 8'h00);
    drain();
    run_line(LINE_CC_ODD, 1'b1, 0, cc_bits(8'h00, 8'h00));
    run_line(LINE_CC_ODD, 1'b0, 2, 26'h0);
    // Copy-generation: stored, auto CRC, field enables, NTSC gate
    cg_case(8'h04, 8'h2a, LINE_CGMS_ODD, 1'b1, 1);
    cg_case(8'h04, 8'h35, LINE_CGMS_ODD, 1'b1, 1);
    cg_case(8'h04, 8'h35, LINE_CGMS_EVEN, 1'b0, 2);
    cg_case(8'h04, 8'h5c, LINE_CGMS_EVEN, 1'b0, 1);
    cg_case(8'h04, 8'h4c, LINE_CGMS_ODD, 1'b1, 2);
    cg_case(8'h00, 8'h73, LINE_CGMS_ODD, 1'b1, 2);
    drain();
    test_done();
  end
endmodule
